// File: src/sorb_report.sv
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module sorb_report
    import sorb_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int USE_MAX = 32
)
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // report request
    input wire logic req_valid,
    input wire sorb_req_s req,
    output logic req_busy,
    output logic req_err,
    // parameter data stream
    output logic out_valid,
    output sorb_byte_s out_byte,
    input wire logic out_ready
);
    localparam int IW = $clog2(DEPTH);
    localparam int UW = $clog2(USE_MAX);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    sorb_entry_s tab_ff [DEPTH];
    logic [7:0] use_mem [DEPTH*USE_MAX];
    logic avail_ff;
    logic [IW:0] count_ff;
    logic [IW-1:0] sel_ff;
    logic [31:0] tnom_ff;
    logic [31:0] trec_ff;
    logic [31:0] rdata_ff;
    sorb_state_e state_ff, nxt_state, sec_nxt;
    logic [UW-1:0] pos_ff, nxt_pos;
    logic [IW-1:0] ent_ff, nxt_ent;
    logic one_ff;
    logic [2:0] sup_ff;
    logic [31:0] alloc_ff;
    logic [31:0] sent_ff;
    logic out_valid_ff;
    sorb_byte_s out_ff;
    logic busy_ff;
    logic err_ff;

    // write decode
    wire wr_ctrl = reg_wr && reg_addr == SORB_REG_CTRL;
    wire wr_sel = reg_wr && reg_addr == SORB_REG_SEL;
    wire wr_ent0 = reg_wr && reg_addr == SORB_REG_ENT0;
    wire wr_ent1 = reg_wr && reg_addr == SORB_REG_ENT1;
    wire wr_use = reg_wr && reg_addr == SORB_REG_USAGE;
    wire wr_tnom = reg_wr && reg_addr == SORB_REG_TNOM;
    wire wr_trec = reg_wr && reg_addr == SORB_REG_TREC;
    wire [UW-1:0] use_widx = reg_wdata[SORB_USE_IDX +: UW];

    // control registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            avail_ff <= 1'b0;
            count_ff <= '0;
            sel_ff <= '0;
            tnom_ff <= 32'h0;
            trec_ff <= 32'h0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                avail_ff <= reg_wdata[SORB_CTRL_AVAIL];
                count_ff <= reg_wdata[SORB_CTRL_CNT +: IW+1];
            end
            if (wr_sel)
                sel_ff <= reg_wdata[IW-1:0];
            if (wr_tnom)
                tnom_ff <= reg_wdata;
            if (wr_trec)
                trec_ff <= reg_wdata;
        end
    end

    // command table, one entry per supported cdb
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
                tab_ff[i] <= '0;
        end
        else if (wr_ent0)
        begin
            tab_ff[sel_ff].opcode <= reg_wdata[7:0];
            tab_ff[sel_ff].sa <= reg_wdata[31:16];
        end
        else if (wr_ent1)
        begin
            tab_ff[sel_ff].cdb_len <= reg_wdata[7:0];
            tab_ff[sel_ff].sa_valid <= reg_wdata[8];
            tab_ff[sel_ff].tdp <= reg_wdata[9];
            tab_ff[sel_ff].vendor <= reg_wdata[10];
        end
    end

    // usage map bytes, software supplies evaluated-bit masks
    always_ff @(posedge clk)
    begin
        if (wr_use)
            use_mem[{sel_ff, use_widx}] <= reg_wdata[7:0];
    end

    // read mux, data valid only in the cycle after the strobe
    wire [31:0] stat_w = {sent_ff[15:0], 9'h0, sup_ff, 1'b0, state_ff};
    wire [31:0] ent0_w = {tab_ff[sel_ff].sa, 8'h0, tab_ff[sel_ff].opcode};
    wire [31:0] ent1_w = {21'h0, tab_ff[sel_ff].vendor, tab_ff[sel_ff].tdp,
                          tab_ff[sel_ff].sa_valid, tab_ff[sel_ff].cdb_len};
    wire [31:0] ctrl_w = {{(32-SORB_CTRL_CNT-IW-1){1'b0}}, count_ff, 7'h0, avail_ff};
    wire [31:0] rd_mux = reg_addr == SORB_REG_CTRL ? ctrl_w :
                         reg_addr == SORB_REG_SEL ? {{(32-IW){1'b0}}, sel_ff} :
                         reg_addr == SORB_REG_ENT0 ? ent0_w :
                         reg_addr == SORB_REG_ENT1 ? ent1_w :
                         reg_addr == SORB_REG_TNOM ? tnom_ff :
                         reg_addr == SORB_REG_TREC ? trec_ff :
                         reg_addr == SORB_REG_STAT ? stat_w : 32'h0;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_ff <= 32'h0;
        else
            rdata_ff <= reg_rd ? rd_mux : 32'h0;
    end

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    logic [15:0] total_len;
    logic found;
    logic [IW-1:0] hit;

    // byte count of the whole all-commands list
    always_comb
    begin
        total_len = 16'(SORB_HDR_BYTES);
        for (int i = 0; i < DEPTH; i++)
            if (i < int'(count_ff))
                total_len = total_len + 16'(SORB_DESC_BYTES) +
                            (tab_ff[i].tdp ? 16'(SORB_TMO_BYTES) : 16'h0);
    end

    // first matching table entry for the requested command
    always_comb
    begin
        found = 1'b0;
        hit = '0;
        for (int i = 0; i < DEPTH; i++)
            if (!found && i < int'(count_ff) && tab_ff[i].opcode == req.opcode &&
                (tab_ff[i].sa_valid ? (req.option != SORB_OPT_OPSA || tab_ff[i].sa == req.sa)
                                    : (req.option != SORB_OPT_OPSA || req.sa == 16'h0)))
            begin
                found = 1'b1;
                hit = IW'(i);
            end
    end

    wire idle = state_ff == SORB_IDLE;
    wire start = req_valid && idle;
    wire opt_one = req.option == SORB_OPT_ONE || req.option == SORB_OPT_OPSA;
    wire opt_ok = req.option == SORB_OPT_ALL || opt_one;
    wire one_sa = req.option == SORB_OPT_ONE && found && tab_ff[hit].sa_valid && avail_ff;
    wire bad = !opt_ok || one_sa;
    // support code, only the four defined values can arise
    wire [2:0] sup_w = !avail_ff ? SORB_SUP_NA :
                       !found ? SORB_SUP_UNSUP :
                       tab_ff[hit].vendor ? SORB_SUP_VEND : SORB_SUP_STD;

    // ------------------------------------------------------------
    // byte builder
    // ------------------------------------------------------------
    sorb_entry_s ent;
    assign ent = tab_ff[ent_ff];
    wire ok1 = sup_ff == SORB_SUP_STD || sup_ff == SORB_SUP_VEND;
    wire [31:0] len32 = {16'h0, total_len - 16'(SORB_HDR_BYTES)};
    wire [7:0] use_raw = use_mem[{ent_ff, pos_ff}];
    wire [7:0] sa_b = ent.sa_valid ? ent.sa[15:8] : 8'h0;
    wire [7:0] sa_l = ent.sa_valid ? ent.sa[7:0] : 8'h0;
    wire [7:0] flg = {6'h0, ent.tdp, ent.sa_valid};
    wire [7:0] h1 = {ok1 && ent.tdp, 4'h0, sup_ff};
    logic [7:0] cur_byte;
    logic [7:0] sec_len;

    // byte at the current position of the current section
    always_comb
    begin
        cur_byte = 8'h0;
        case (state_ff)
            SORB_HDR:
                if (!one_ff)
                    cur_byte = len32[8*(3-int'(pos_ff)) +: 8];
                else if (pos_ff == UW'(1))
                    cur_byte = h1;
                else if (pos_ff == UW'(3))
                    cur_byte = ok1 ? ent.cdb_len : 8'h0;
            SORB_DESC:
                case (pos_ff)
                    UW'(0): cur_byte = ent.opcode;
                    UW'(2): cur_byte = sa_b;
                    UW'(3): cur_byte = sa_l;
                    UW'(5): cur_byte = flg;
                    UW'(7): cur_byte = ent.cdb_len;
                    default: cur_byte = 8'h0;
                endcase
            SORB_USE:
                if (pos_ff == '0)
                    cur_byte = ent.opcode;
                else if (ent.sa_valid && pos_ff == SORB_SA_BYTE)
                    cur_byte = {use_raw[7:SORB_SA_BITS], ent.sa[SORB_SA_BITS-1:0]};
                else
                    cur_byte = use_raw;
            SORB_TMO:
                if (pos_ff == UW'(1))
                    cur_byte = SORB_TMO_LEN;
                else if (pos_ff >= UW'(4) && pos_ff < UW'(8))
                    cur_byte = tnom_ff[8*(7-int'(pos_ff)) +: 8];
                else if (pos_ff >= UW'(8))
                    cur_byte = trec_ff[8*(11-int'(pos_ff)) +: 8];
            default: cur_byte = 8'h0;
        endcase
    end

    // section length and the section that follows it
    wire more = {1'b0, ent_ff} + 1'b1 < count_ff;
    always_comb
    begin
        sec_len = SORB_HDR_BYTES;
        sec_nxt = SORB_IDLE;
        case (state_ff)
            SORB_HDR:
                if (one_ff)
                    sec_nxt = ok1 ? SORB_USE : SORB_IDLE;
                else
                    sec_nxt = count_ff != '0 ? SORB_DESC : SORB_IDLE;
            SORB_DESC:
            begin
                sec_len = SORB_DESC_BYTES;
                sec_nxt = ent.tdp ? SORB_TMO : more ? SORB_DESC : SORB_IDLE;
            end
            SORB_USE:
            begin
                sec_len = ent.cdb_len;
                sec_nxt = ent.tdp ? SORB_TMO : SORB_IDLE;
            end
            SORB_TMO:
            begin
                sec_len = SORB_TMO_BYTES;
                sec_nxt = !one_ff && more ? SORB_DESC : SORB_IDLE;
            end
            default: sec_nxt = SORB_IDLE;
        endcase
    end

    wire adv = !idle && (!out_valid_ff || out_ready);
    wire sec_end = {{(8-UW){1'b0}}, pos_ff} == sec_len - 8'h01;
    wire trunc = sent_ff + 32'h1 == alloc_ff;
    wire last_now = (sec_end && sec_nxt == SORB_IDLE) || trunc;
    wire next_ent = state_ff == SORB_TMO || (state_ff == SORB_DESC && !ent.tdp);

    // sequencing of sections and entries
    always_comb
    begin
        nxt_state = state_ff;
        nxt_pos = pos_ff;
        nxt_ent = ent_ff;
        if (start && !bad && req.alloc != 32'h0)
        begin
            nxt_state = SORB_HDR;
            nxt_pos = '0;
            nxt_ent = opt_one ? hit : '0;
        end
        else if (adv)
        begin
            if (last_now)
                nxt_state = SORB_IDLE;
            else if (!sec_end)
                nxt_pos = pos_ff + 1'b1;
            else
            begin
                nxt_state = sec_nxt;
                nxt_pos = '0;
                if (state_ff == SORB_HDR && !one_ff)
                    nxt_ent = '0;
                else if (next_ent)
                    nxt_ent = ent_ff + 1'b1;
            end
        end
    end

    // request capture and state
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= SORB_IDLE;
            pos_ff <= '0;
            ent_ff <= '0;
            one_ff <= 1'b0;
            sup_ff <= SORB_SUP_NA;
            alloc_ff <= 32'h0;
            sent_ff <= 32'h0;
            busy_ff <= 1'b0;
            err_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            pos_ff <= nxt_pos;
            ent_ff <= nxt_ent;
            busy_ff <= nxt_state != SORB_IDLE;
            err_ff <= start && bad;
            if (start)
            begin
                one_ff <= opt_one;
                sup_ff <= sup_w;
                alloc_ff <= req.alloc;
                sent_ff <= 32'h0;
            end
            else if (adv)
                sent_ff <= sent_ff + 32'h1;
        end
    end

    // output byte register with back-pressure
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_valid_ff <= 1'b0;
            out_ff <= '0;
        end
        else if (adv)
        begin
            out_valid_ff <= 1'b1;
            out_ff <= '{data: cur_byte, last: last_now};
        end
        else if (out_ready)
            out_valid_ff <= 1'b0;
    end

    assign reg_rdata = rdata_ff;
    assign req_busy = busy_ff;
    assign req_err = err_ff;
    assign out_valid = out_valid_ff;
    assign out_byte = out_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_desc_end;
        adv && state_ff == SORB_DESC && sec_end && !trunc;
    endsequence

    a_hdr_first: assert property (start && !bad && req.alloc != 32'h0 |=>
        state_ff == SORB_HDR && pos_ff == '0) else $error("header not first");
    a_desc_tmo: assert property (s_desc_end ##0 ent.tdp |=> state_ff == SORB_TMO)
        else $error("timeout descriptor missing");
    a_desc_rsvd: assert property (state_ff == SORB_DESC && (pos_ff == UW'(1) ||
        pos_ff == UW'(4)) |-> cur_byte == 8'h0) else $error("reserved byte not zero");
    a_sa_zero: assert property (state_ff == SORB_DESC && !ent.sa_valid &&
        (pos_ff == UW'(2) || pos_ff == UW'(3)) |-> cur_byte == 8'h0) else $error("sa not zero");
    a_tmo_len: assert property (adv && state_ff == SORB_TMO && pos_ff == UW'(1) |=>
        out_ff.data == 8'h0A) else $error("timeout length wrong");
    a_trunc_cap: assert property (out_valid_ff |-> sent_ff <= alloc_ff)
        else $error("more bytes than allocated");
    a_trunc_end: assert property (adv && trunc |=> out_ff.last && idle)
        else $error("truncation missed");
    a_sup_legal: assert property (busy_ff && one_ff |-> sup_ff != 3'h2 &&
        sup_ff != 3'h4 && sup_ff < 3'h6) else $error("reserved support code");
    a_use_opcode: assert property (state_ff == SORB_USE && pos_ff == '0 |->
        cur_byte == tab_ff[ent_ff].opcode) else $error("usage byte 0 wrong");
    a_one_mode: assert property (start && !bad && req.option == SORB_OPT_ONE |=>
        one_ff) else $error("layout not selected");
    a_na_short: assert property (state_ff == SORB_HDR && one_ff && !ok1 &&
        pos_ff == UW'(3) |-> cur_byte == 8'h0) else $error("invalid size sent");
endmodule

// File: src/sorb_pkg.sv
// Behaviour
// - all-commands data opens with four-byte length header
// - one descriptor per supported cdb, from byte 4
// - descriptor bytes: opcode, zero, action, zero, flags
// - no service actions gives zero action field
// - timeout flag set only with appended timeout descriptor
// - action-valid flag marks opcodes having service actions
// - descriptor bytes 6-7 carry cdb length
// - one-command: zero, flags and support, size, usage
// - one-command timeout descriptor follows usage, flag set
// - support code 000b means data unavailable now
// - support code 001b marks unsupported command
// - codes 011b standard, 101b vendor specific support
// - cdb size equals usage length and cdb bytes
// - first usage byte holds the operation code
// - service action sits at its cdb location
// - usage bits map cdb bits, one when evaluated
// - ignored or reserved cdb fields give zero bits
// - reporting option selects all or one-command layout
// - short allocation truncates, leading part sent
// - timeout descriptor starts with length 0Ah
package sorb_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] SORB_REG_CTRL = 8'h00;
    localparam logic [7:0] SORB_REG_SEL = 8'h04;
    localparam logic [7:0] SORB_REG_ENT0 = 8'h08;
    localparam logic [7:0] SORB_REG_ENT1 = 8'h0C;
    localparam logic [7:0] SORB_REG_USAGE = 8'h10;
    localparam logic [7:0] SORB_REG_TNOM = 8'h14;
    localparam logic [7:0] SORB_REG_TREC = 8'h18;
    localparam logic [7:0] SORB_REG_STAT = 8'h1C;
    localparam int SORB_CTRL_AVAIL = 0;
    localparam int SORB_CTRL_CNT = 8;
    localparam int SORB_USE_IDX = 8;
    // ------------------------------------------------------------
    // request options and support codes
    // ------------------------------------------------------------
    localparam logic [2:0] SORB_OPT_ALL = 3'h0;
    localparam logic [2:0] SORB_OPT_ONE = 3'h1;
    localparam logic [2:0] SORB_OPT_OPSA = 3'h3;
    localparam logic [2:0] SORB_SUP_NA = 3'h0;
    localparam logic [2:0] SORB_SUP_UNSUP = 3'h1;
    localparam logic [2:0] SORB_SUP_STD = 3'h3;
    localparam logic [2:0] SORB_SUP_VEND = 3'h5;
    // ------------------------------------------------------------
    // layout
    // ------------------------------------------------------------
    localparam logic [7:0] SORB_HDR_BYTES = 8'h04;
    localparam logic [7:0] SORB_DESC_BYTES = 8'h08;
    localparam logic [7:0] SORB_TMO_BYTES = 8'h0C;
    localparam logic [7:0] SORB_TMO_LEN = 8'h0A;
    localparam logic [4:0] SORB_SA_BYTE = 5'h01;
    localparam int SORB_SA_BITS = 5;
    localparam int SORB_F_TDP = 1;
    localparam int SORB_F_SAV = 0;
    localparam int SORB_H1_TDP = 7;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic vendor;
        logic tdp;
        logic sa_valid;
        logic [7:0] cdb_len;
        logic [15:0] sa;
        logic [7:0] opcode;
    } sorb_entry_s;
    typedef struct packed {
        logic [2:0] option;
        logic [7:0] opcode;
        logic [15:0] sa;
        logic [31:0] alloc;
    } sorb_req_s;
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } sorb_byte_s;
    typedef enum logic [2:0] {
        SORB_IDLE = 3'b000,
        SORB_HDR = 3'b001,
        SORB_DESC = 3'b010,
        SORB_USE = 3'b011,
        SORB_TMO = 3'b100
    } sorb_state_e;
endpackage

// File: bench/sorb_sink.sv
`timescale 1ns/1ps
module sorb_sink
    import sorb_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // stream from the report builder
    input wire logic out_valid,
    input wire sorb_byte_s out_byte,
    output logic out_ready,
    // slow consumer mode
    input wire logic stall
);
    sorb_byte_s got[$];
    logic [2:0] cnt_ff;

    // ------------------------------------------------------------
    // receiving side of the stream
    // ------------------------------------------------------------
    // ready is irregular in stall mode so held bytes are exercised
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_ff <= 3'h0;
            out_ready <= 1'h0;
        end
        else
        begin
            cnt_ff <= cnt_ff + 3'h1;
            out_ready <= !stall || (cnt_ff[0] ^ cnt_ff[2]);
        end
    end

    // bytes are kept raw; the action field is never interpreted here
    always @(posedge clk)
    begin
        if (arst_n && out_valid && out_ready)
            got.push_back(out_byte);
    end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import sorb_pkg::*;
();
    logic clk;
    logic arst_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic req_valid;
    sorb_req_s req;
    logic req_busy;
    logic req_err;
    logic out_valid;
    sorb_byte_s out_byte;
    logic out_ready;
    logic stall;
    int err_total = 0;
    int checks = 0;
    int err_seen = 0;
    logic [7:0] exp_q[$];

    sorb_report #(.DEPTH(16), .USE_MAX(32)) DUT (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req), .req_busy(req_busy),
        .req_err(req_err), .out_valid(out_valid), .out_byte(out_byte),
        .out_ready(out_ready));
    sorb_sink u_sink (.clk(clk), .arst_n(arst_n), .out_valid(out_valid),
        .out_byte(out_byte), .out_ready(out_ready), .stall(stall));

    // ------------------------------------------------------------
    // clock, refusal counter, watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (req_err === 1'h1)
            err_seen++;
    end

    initial
    begin
        #50000;
        err_total++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        if (err_total == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk("register", e, reg_rdata);
    endtask

    // one table entry: flags are {vendor, timeout present, action valid}
    task automatic ent(input logic [3:0] ix, input logic [7:0] op, input logic [15:0] s,
        input logic [7:0] len, input logic [2:0] fl);
        wr(SORB_REG_SEL, {28'h0, ix});
        wr(SORB_REG_ENT0, {s, 8'h00, op});
        wr(SORB_REG_ENT1, {21'h0, fl, len});
    endtask

    function automatic logic [7:0] ub(input int i, input logic [7:0] op, input logic [7:0] b1);
        return (i == 0) ? op : ((i == 1) ? b1 : 8'(8'hC0 + i));
    endfunction

    task automatic ufill(input logic [3:0] ix, input int n, input logic [7:0] op,
        input logic [7:0] b1);
        wr(SORB_REG_SEL, {28'h0, ix});
        for (int i = 0; i < n; i++)
            wr(SORB_REG_USAGE, {19'h0, 5'(i), ub(i, op, b1)});
    endtask

    task automatic uexp(input int n, input logic [7:0] op, input logic [7:0] b1);
        for (int i = 0; i < n; i++)
            exp_q.push_back(ub(i, op, b1));
    endtask

    // big-endian word into the expected stream
    task automatic put(input logic [31:0] w);
        exp_q.push_back(w[31:24]);
        exp_q.push_back(w[23:16]);
        exp_q.push_back(w[15:8]);
        exp_q.push_back(w[7:0]);
    endtask

    task automatic tmo_exp();
        put(32'h000A_0000);
        put(32'h0102_0304);
        put(32'h0506_0708);
    endtask

    task automatic all_exp();
        put(32'h0000_001C);
        put(32'h1200_0000);
        put(32'h0000_0006);
        put(32'h9E00_0010);
        put(32'h0003_0010);
        tmo_exp();
    endtask

    // issue one request, drain the stream, compare against exp_q cut to alloc
    task automatic run(input logic [2:0] o, input logic [7:0] oc, input logic [15:0] s,
        input logic [31:0] al, input logic e);
        int n;
        int k;
        n = err_seen;
        k = 0;
        u_sink.got.delete();
        while (32'(exp_q.size()) > al)
            void'(exp_q.pop_back());
        @(posedge clk);
        req_valid <= 1'h1;
        req <= '{o, oc, s, al};
        @(posedge clk);
        req_valid <= 1'h0;
        #1 chk("busy", 32'(!e && al != 32'h0), 32'(req_busy));
        repeat (3) @(posedge clk);
        while (req_busy === 1'h1 && k < 4000)
        begin
            @(posedge clk);
            k++;
        end
        repeat (8) @(posedge clk);
        chk("finish", 32'h0, 32'(k >= 4000));
        chk("refusal", 32'(e), 32'(err_seen != n));
        chk("length", 32'(exp_q.size()), 32'(u_sink.got.size()));
        foreach (exp_q[i])
        begin
            if (i < u_sink.got.size())
            begin
                chk("byte", 32'(exp_q[i]), 32'(u_sink.got[i].data));
                chk("last", 32'(i == exp_q.size() - 1), 32'(u_sink.got[i].last));
            end
        end
        exp_q.delete();
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        arst_n = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        req_valid = 1'h0;
        req = '0;
        stall = 1'h0;
        repeat (5) @(posedge clk);
        arst_n <= 1'h1;
        rchk(SORB_REG_ENT0, 32'h0);
        wr(SORB_REG_CTRL, 32'h0000_0201);
        ent(4'h0, 8'h12, 16'h0000, 8'h06, 3'h0);
        ufill(4'h0, 6, 8'h12, 8'hA5);
        ent(4'h1, 8'h9E, 16'h0010, 8'h10, 3'h3);
        ufill(4'h1, 16, 8'h9E, 8'hE5);
        wr(SORB_REG_TNOM, 32'h0102_0304);
        wr(SORB_REG_TREC, 32'h0506_0708);
        rchk(SORB_REG_ENT0, 32'h0010_009E);
        rchk(SORB_REG_ENT1, 32'h0000_0310);
        rchk(SORB_REG_SEL, 32'h0000_0001);
        rchk(SORB_REG_CTRL, 32'h0000_0201);
        rchk(SORB_REG_TNOM, 32'h0102_0304);
        rchk(SORB_REG_TREC, 32'h0506_0708);
        rchk(SORB_REG_USAGE, 32'h0);
        rchk(8'h20, 32'h0);
        // full list with a slow consumer, then cut short twice
        stall <= 1'h1;
        all_exp();
        run(SORB_OPT_ALL, 8'h00, 16'h0, 32'h100, 1'h0);
        stall <= 1'h0;
        all_exp();
        run(SORB_OPT_ALL, 8'h00, 16'h0, 32'h5, 1'h0);
        all_exp();
        run(SORB_OPT_ALL, 8'h00, 16'h0, 32'h0, 1'h0);
        // one-command layouts
        put(32'h0003_0006);
        uexp(6, 8'h12, 8'hA5);
        run(SORB_OPT_ONE, 8'h12, 16'h0, 32'h100, 1'h0);
        put(32'h0083_0010);
        uexp(16, 8'h9E, 8'hF0);
        tmo_exp();
        run(SORB_OPT_OPSA, 8'h9E, 16'h0010, 32'h100, 1'h0);
        put(32'h0001_0000);
        run(SORB_OPT_ONE, 8'h55, 16'h0, 32'h100, 1'h0);
        rchk(SORB_REG_STAT, 32'h0004_0010);
        // service action that no entry carries, then refused requests
        put(32'h0001_0000);
        run(SORB_OPT_OPSA, 8'h9E, 16'h0011, 32'h100, 1'h0);
        run(SORB_OPT_ONE, 8'h9E, 16'h0, 32'h100, 1'h1);
        for (int o = 2; o < 8; o++)
        begin
            if (o != 3)
                run(3'(o), 8'h12, 16'h0, 32'h100, 1'h1);
        end
        // empty command list gives the header alone
        wr(SORB_REG_CTRL, 32'h0000_0001);
        put(32'h0000_0000);
        run(SORB_OPT_ALL, 8'h00, 16'h0, 32'h100, 1'h0);
        // data unavailable, then retried once available with vendor support
        wr(SORB_REG_CTRL, 32'h0000_0200);
        put(32'h0000_0000);
        run(SORB_OPT_ONE, 8'h12, 16'h0, 32'h100, 1'h0);
        wr(SORB_REG_CTRL, 32'h0000_0201);
        ent(4'h0, 8'h12, 16'h0000, 8'h06, 3'h4);
        put(32'h0005_0006);
        uexp(6, 8'h12, 8'hA5);
        run(SORB_OPT_ONE, 8'h12, 16'h0, 32'h100, 1'h0);
        report_and_stop();
    end
endmodule
